// ---- core/vemc_mode_ctrl.sv ----
// Purpose: mode control register group of a digital video encoder
// Assumes: a serial-bus slave front end presents byte writes and reads
//          as a subaddress, data and one-cycle strobes on clk_sys
// Notes:   reads return the stored byte one cycle after the strobe;
//          caption byte is shifted out lsb first on request
`timescale 1ns/1ps
`default_nettype none

module vemc_mode_ctrl (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // byte register port from the serial bus slave
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata_q,
   output logic             reg_hit_q,
   // external realtime subcarrier increment
   input  wire logic [31:0] rt_increment,
   input  wire logic        rt_phase_alt,
   // caption serializer handshake
   input  wire logic        caption_start,
   input  wire logic        caption_bit_en,
   output logic             caption_bit_q,
   output logic             caption_busy_q,
   // encoder settings
   output logic             rgb_dac_powerdown_q,
   output logic             composite_dac_powerdown_q,
   output logic             alt_phase_invert_q,
   output logic             luma_gain_setup_select_q,
   output logic             secam_enable_q,
   output logic             chroma_bandwidth_select_q,
   output logic             pal_select_q,
   output logic             line_length_select_q,
   output logic      [9:0]  line_length_q,
   output logic             realtime_ctrl_enable_q,
   output logic      [6:0]  burst_amplitude_q,
   output logic      [31:0] subcarrier_increment_q
);

   // ****************************************************************
   // register storage
   // ****************************************************************
   logic [7:0] std_dac_q;
   logic [7:0] rt_burst_q;
   logic [7:0] sc_byte_q [4];
   logic [7:0] caption_q;
   logic [7:0] sc_addr [4];

   assign sc_addr[0] = vemc_pkg::ADDR_SC_BYTE0;
   assign sc_addr[1] = vemc_pkg::ADDR_SC_BYTE1;
   assign sc_addr[2] = vemc_pkg::ADDR_SC_BYTE2;
   assign sc_addr[3] = vemc_pkg::ADDR_SC_BYTE3;

   vemc_reg8 #(
      .RESET_VAL (vemc_pkg::RST_STD_DAC)
   ) u_std_dac (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .wr_en   (reg_wr && reg_addr == vemc_pkg::ADDR_STD_DAC),
      .wr_data (reg_wdata),
      .value_q (std_dac_q)
   );

   vemc_reg8 #(
      .RESET_VAL (vemc_pkg::RST_RT_BURST)
   ) u_rt_burst (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .wr_en   (reg_wr && reg_addr == vemc_pkg::ADDR_RT_BURST),
      .wr_data (reg_wdata),
      .value_q (rt_burst_q)
   );

   for (genvar i = 0; i < 4; i++) begin : g_sc
      vemc_reg8 #(
         .RESET_VAL (vemc_pkg::RST_SC_BYTE)
      ) u_sc (
         .clk_sys (clk_sys),
         .resetn  (resetn),
         .wr_en   (reg_wr && reg_addr == sc_addr[i]),
         .wr_data (reg_wdata),
         .value_q (sc_byte_q[i])
      );
   end

   vemc_reg8 #(
      .RESET_VAL (vemc_pkg::RST_CAPTION)
   ) u_caption (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .wr_en   (reg_wr && reg_addr == vemc_pkg::ADDR_CAPTION),
      .wr_data (reg_wdata),
      .value_q (caption_q)
   );

   // ****************************************************************
   // read path
   // ****************************************************************
   logic [7:0] rdata_d;
   logic       hit_d;

   always_comb begin
      rdata_d = 8'h00;
      hit_d   = 1'b1;
      unique case (reg_addr)
         vemc_pkg::ADDR_STD_DAC:  rdata_d = std_dac_q;
         vemc_pkg::ADDR_RT_BURST: rdata_d = rt_burst_q;
         vemc_pkg::ADDR_SC_BYTE0: rdata_d = sc_byte_q[0];
         vemc_pkg::ADDR_SC_BYTE1: rdata_d = sc_byte_q[1];
         vemc_pkg::ADDR_SC_BYTE2: rdata_d = sc_byte_q[2];
         vemc_pkg::ADDR_SC_BYTE3: rdata_d = sc_byte_q[3];
         vemc_pkg::ADDR_CAPTION:  rdata_d = caption_q;
         default:                 hit_d   = 1'b0;
      endcase
   end

   // unmapped subaddresses read as zero with hit low
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 8'h00;
         reg_hit_q   <= 1'b0;
      end else if (reg_rd) begin
         reg_rdata_q <= rdata_d;
         reg_hit_q   <= hit_d;
      end
   end

   // ****************************************************************
   // decoded settings
   // ****************************************************************
   // host must not set secam with pal; secam wins here so output stays
   // defined even if it does
   localparam logic [7:0] RSTV = vemc_pkg::RST_STD_DAC;
   logic secam_w;
   assign secam_w = std_dac_q[vemc_pkg::BIT_SECAM];

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rgb_dac_powerdown_q       <= RSTV[vemc_pkg::BIT_RGB_PD];
         composite_dac_powerdown_q <= RSTV[vemc_pkg::BIT_COMP_PD];
         luma_gain_setup_select_q  <= RSTV[vemc_pkg::BIT_LUMA_GS];
         secam_enable_q            <= RSTV[vemc_pkg::BIT_SECAM];
         chroma_bandwidth_select_q <= RSTV[vemc_pkg::BIT_CHROMA_BW];
         pal_select_q              <= RSTV[vemc_pkg::BIT_PAL];
         line_length_select_q      <= RSTV[vemc_pkg::BIT_LINE_LEN];
      end else begin
         rgb_dac_powerdown_q       <= std_dac_q[vemc_pkg::BIT_RGB_PD];
         composite_dac_powerdown_q <= std_dac_q[vemc_pkg::BIT_COMP_PD];
         luma_gain_setup_select_q  <= std_dac_q[vemc_pkg::BIT_LUMA_GS];
         secam_enable_q            <= secam_w;
         chroma_bandwidth_select_q <= std_dac_q[vemc_pkg::BIT_CHROMA_BW];
         pal_select_q              <= std_dac_q[vemc_pkg::BIT_PAL] & ~secam_w;
         line_length_select_q      <= std_dac_q[vemc_pkg::BIT_LINE_LEN];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         line_length_q <= vemc_pkg::LINE_LEN_LONG;
      end else if (std_dac_q[vemc_pkg::BIT_LINE_LEN]) begin
         line_length_q <= vemc_pkg::LINE_LEN_SHORT;
      end else begin
         line_length_q <= vemc_pkg::LINE_LEN_LONG;
      end
   end

   // phase invert only meaningful under realtime control
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         alt_phase_invert_q <= RSTV[vemc_pkg::BIT_PH_INV];
      end else begin
         alt_phase_invert_q <= std_dac_q[vemc_pkg::BIT_PH_INV]
                             & rt_burst_q[vemc_pkg::BIT_RTC_EN]
                             & rt_phase_alt;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         realtime_ctrl_enable_q <= 1'b0;
         burst_amplitude_q      <= vemc_pkg::RST_RT_BURST[vemc_pkg::BURST_MSB:0];
      end else begin
         realtime_ctrl_enable_q <= rt_burst_q[vemc_pkg::BIT_RTC_EN];
         if (secam_w) begin
            burst_amplitude_q <= vemc_pkg::SECAM_BURST;
         end else begin
            burst_amplitude_q <= rt_burst_q[vemc_pkg::BURST_MSB:0];
         end
      end
   end

   // realtime input replaces the programmed increment while enabled
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         subcarrier_increment_q <= {4{vemc_pkg::RST_SC_BYTE}};
      end else if (rt_burst_q[vemc_pkg::BIT_RTC_EN]) begin
         subcarrier_increment_q <= rt_increment;
      end else begin
         subcarrier_increment_q <= {sc_byte_q[3], sc_byte_q[2],
                                    sc_byte_q[1], sc_byte_q[0]};
      end
   end

   // ****************************************************************
   // caption byte serializer
   // ****************************************************************
   // byte is captured at start so a rewrite mid-line cannot tear it
   logic [7:0] cap_shift_q;
   logic [3:0] cap_cnt_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cap_shift_q    <= 8'h00;
         cap_cnt_q      <= 4'h0;
         caption_busy_q <= 1'b0;
         caption_bit_q  <= 1'b0;
      end else if (caption_start && !caption_busy_q) begin
         cap_shift_q    <= caption_q;
         cap_cnt_q      <= 4'h0;
         caption_busy_q <= 1'b1;
         caption_bit_q  <= 1'b0;
      end else if (caption_busy_q && caption_bit_en) begin
         caption_bit_q <= cap_shift_q[0];
         cap_shift_q   <= {1'b0, cap_shift_q[7:1]};
         cap_cnt_q     <= cap_cnt_q + 4'h1;
         if (cap_cnt_q == 4'(vemc_pkg::CAP_BITS - 1)) begin
            caption_busy_q <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ---- core/vemc_pkg.sv ----
// Purpose: constants for the encoder mode control register group
// Assumes: byte-wide registers addressed by subaddress
// Notes:   register widths are fixed at eight bits
package vemc_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // ****************************************************************
   // subaddresses
   // ****************************************************************
   localparam logic [7:0] ADDR_STD_DAC   = 8'h61;
   localparam logic [7:0] ADDR_RT_BURST  = 8'h62;
   localparam logic [7:0] ADDR_SC_BYTE0  = 8'h63;
   localparam logic [7:0] ADDR_SC_BYTE1  = 8'h64;
   localparam logic [7:0] ADDR_SC_BYTE2  = 8'h65;
   localparam logic [7:0] ADDR_SC_BYTE3  = 8'h66;
   localparam logic [7:0] ADDR_CAPTION   = 8'h67;

   // ****************************************************************
   // field positions, standard and dac control
   // ****************************************************************
   localparam int unsigned BIT_RGB_PD    = 7;
   localparam int unsigned BIT_COMP_PD   = 6;
   localparam int unsigned BIT_PH_INV    = 5;
   localparam int unsigned BIT_LUMA_GS   = 4;
   localparam int unsigned BIT_SECAM     = 3;
   localparam int unsigned BIT_CHROMA_BW = 2;
   localparam int unsigned BIT_PAL       = 1;
   localparam int unsigned BIT_LINE_LEN  = 0;

   // ****************************************************************
   // field positions, realtime and burst control
   // ****************************************************************
   localparam int unsigned BIT_RTC_EN    = 7;
   localparam int unsigned BURST_MSB     = 6;
   localparam int unsigned BURST_W       = 7;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] RST_STD_DAC    = 8'h86;
   localparam logic [7:0] RST_RT_BURST   = 8'h2f;
   localparam logic [7:0] RST_SC_BYTE    = 8'h00;
   localparam logic [7:0] RST_CAPTION    = 8'h00;

   // ****************************************************************
   // encoding constants
   // ****************************************************************
   localparam logic [9:0] LINE_LEN_LONG  = 10'h360;
   localparam logic [9:0] LINE_LEN_SHORT = 10'h35a;
   localparam logic [6:0] SECAM_BURST    = 7'h2f;
   localparam int unsigned CAP_BITS      = 8;
endpackage

// ---- core/vemc_reg8.sv ----
// Purpose: one byte-wide control register with write enable
// Assumes: write strobe synchronous to clk_sys
// Notes:   value holds until rewritten or reset
`timescale 1ns/1ps
`default_nettype none
module vemc_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] value_q
);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         value_q <= RESET_VAL;
      end else if (wr_en) begin
         value_q <= wr_data;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for vemc_mode_ctrl
// Assumes: host model drives the byte register port
// Notes:   burst and increment values are random in the random write test, bounded by width
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0, resetn = 1'b0, phs = 1'b0, cs = 1'b0, be = 1'b0;
   logic [31:0] rti = 32'h0;
   logic [7:0] ad, wd, rv, ra, m[8];
   logic [7:0] rdq;
   logic hit, cb, cbusy, wr, rd;
   wire [57:0] got;
   int failures = 0, n_compared = 0;
   always #2 clk_sys = ~clk_sys;
   vemc_host vemc_host_i (.clk_sys(clk_sys), .reg_rdata_q(rdq),
      .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd));
   vemc_mode_ctrl vemc_mode_ctrl_i (.clk_sys(clk_sys), .resetn(resetn),
      .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata_q(rdq), .reg_hit_q(hit), .rt_increment(rti),
      .rt_phase_alt(phs), .caption_start(cs), .caption_bit_en(be),
      .caption_bit_q(cb), .caption_busy_q(cbusy),
      .rgb_dac_powerdown_q(got[57]), .composite_dac_powerdown_q(got[56]),
      .alt_phase_invert_q(got[55]), .luma_gain_setup_select_q(got[54]),
      .secam_enable_q(got[53]), .chroma_bandwidth_select_q(got[52]),
      .pal_select_q(got[51]), .line_length_select_q(got[50]),
      .line_length_q(got[49:40]), .realtime_ctrl_enable_q(got[39]),
      .burst_amplitude_q(got[38:32]), .subcarrier_increment_q(got[31:0]));
   // expected decoded outputs from the stored bytes
   function automatic logic [57:0] expv();
      logic [7:0] a;
      a = m[0];
      return {a[7:6], a[5] & m[1][7] & phs, a[4:2], a[1] & ~a[3], a[0],
         a[0] ? 10'h35a : 10'h360, m[1][7], a[3] ? 7'h2f : m[1][6:0],
         m[1][7] ? rti : {m[5], m[4], m[3], m[2]}};
   endfunction
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic do_reset();
      resetn = 1'b0;
      m = '{8'h86, 8'h2f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (20) @(posedge clk_sys);
      #1 resetn = 1'b1;
      chk(got, expv());
      for (int i = 0; i < 7; i++) begin
         vemc_host_i.rd(8'h61 + i[7:0], rv);
         chk({hit, rv}, {1'b1, m[i]});
      end
   endtask
   task automatic close_out();
      $display("compared %0d failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000 failures++;
      close_out();
   end
   initial begin
      void'($urandom(92));
      rti = $urandom();
      phs = 1'b1;
      do_reset();
      $display("test reset done");
      for (int n = 0; n < 60; n++) begin
         rti = $urandom();
         phs = 1'($urandom());
         ra = 8'h61 + 8'($urandom_range(6));
         rv = 8'($urandom());
         vemc_host_i.wr((n % 9 == 4) ? 8'h68 : ra, rv);
         if (n % 9 != 4) begin
            m[ra - 8'h61] = rv;
            if (ra == 8'h61 && rv[3]) m[0][1] = 1'b0;
            if (ra == 8'h67) m[6][7] = ~^rv[6:0];
         end
         @(posedge clk_sys);
         #1 chk(got, expv());
         vemc_host_i.rd((n % 5 == 0) ? 8'h5f : 8'h61 + 8'(n % 7), rv);
         chk({hit, rv}, (n % 5 == 0) ? 9'h0 : {1'b1, m[n % 7]});
      end
      $display("test random writes done");
      vemc_host_i.wr(8'h67, 8'h5a);
      m[6] = {~^7'h5a, 7'h5a};
      @(posedge clk_sys);
      #1 cs = 1'b1;
      @(posedge clk_sys);
      #1 cs = 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         #1 be = 1'b1;
         @(posedge clk_sys);
         #1 be = 1'b0;
         chk(cb, m[6][i]);
      end
      chk(cbusy, 1'b0);
      $display("test caption done");
      for (int k = 0; k < 4; k++) begin
         vemc_host_i.setup(k[1], k[0]);
         m[0] = {3'b000, k[0], 1'b0, 1'b1, k[1], ~k[1]};
         m[1] = k[1] ? (k[0] ? 8'h2d : 8'h2f) : (k[0] ? 8'h3f : 8'h43);
         {m[5], m[4], m[3], m[2]} = k[1] ? 32'h2a09_8acb : 32'h21f0_7c1f;
         @(posedge clk_sys);
         #1 chk(got, expv());
      end
      $display("test recommended settings done");
      do_reset();
      $display("test second reset done");
      close_out();
   end
endmodule
`default_nettype wire

// ---- testbench/vemc_chk.sv ----
// Purpose: port-level checker for the mode control group
// Assumes: bound to vemc_mode_ctrl, one clock domain
// Notes:   write effects are checked two edges after the write
`timescale 1ns/1ps
`default_nettype none
module vemc_chk (
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_q,
   input wire logic       reg_hit_q,
   input wire logic       caption_start,
   input wire logic       caption_busy_q,
   input wire logic       rgb_dac_powerdown_q,
   input wire logic       secam_enable_q,
   input wire logic       pal_select_q,
   input wire logic       line_length_select_q,
   input wire logic [9:0] line_length_q,
   input wire logic       realtime_ctrl_enable_q,
   input wire logic [6:0] burst_amplitude_q
);
   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   property p_len;
      line_length_q == (line_length_select_q ? 10'h35a : 10'h360);
   endproperty
   a_len: assert property (p_len) else $error("line length off");
   property p_pal; secam_enable_q |-> !pal_select_q; endproperty
   a_pal: assert property (p_pal) else $error("pal with secam");
   property p_bst; secam_enable_q |-> burst_amplitude_q == 7'h2f; endproperty
   a_bst: assert property (p_bst) else $error("secam burst");
   property p_rgb;
      reg_wr && reg_addr == 8'h61 && reg_wdata[7] |-> ##2 rgb_dac_powerdown_q;
   endproperty
   a_rgb: assert property (p_rgb) else $error("rgb powerdown");
   property p_rtc;
      reg_wr && reg_addr == 8'h62 && !reg_wdata[7] |->
         ##2 !realtime_ctrl_enable_q;
   endproperty
   a_rtc: assert property (p_rtc) else $error("realtime enable");
   property p_hit;
      reg_rd && reg_addr inside {[8'h61:8'h67]} |=> reg_hit_q;
   endproperty
   a_hit: assert property (p_hit) else $error("read miss");
   property p_unm;
      reg_rd && !(reg_addr inside {[8'h61:8'h67]}) |=>
         !reg_hit_q && reg_rdata_q == 8'h00;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read");
   property p_rdh; !reg_rd |=> $stable(reg_rdata_q); endproperty
   a_rdh: assert property (p_rdh) else $error("read data moved");
   property p_cap; caption_start && !caption_busy_q |=> caption_busy_q;
   endproperty
   a_cap: assert property (p_cap) else $error("caption not busy");
endmodule
bind vemc_mode_ctrl vemc_chk vemc_chk_i (
   .clk_sys                (clk_sys),
   .resetn                 (resetn),
   .reg_addr               (reg_addr),
   .reg_wdata              (reg_wdata),
   .reg_wr                 (reg_wr),
   .reg_rd                 (reg_rd),
   .reg_rdata_q            (reg_rdata_q),
   .reg_hit_q              (reg_hit_q),
   .caption_start          (caption_start),
   .caption_busy_q         (caption_busy_q),
   .rgb_dac_powerdown_q    (rgb_dac_powerdown_q),
   .secam_enable_q         (secam_enable_q),
   .pal_select_q           (pal_select_q),
   .line_length_select_q   (line_length_select_q),
   .line_length_q          (line_length_q),
   .realtime_ctrl_enable_q (realtime_ctrl_enable_q),
   .burst_amplitude_q      (burst_amplitude_q)
);
`default_nettype wire

// ---- testbench/vemc_host.sv ----
// Purpose: host model issuing byte writes and reads
// Assumes: signals change 1 ns after the rising edge
// Notes:   idle data lines show inverted last value
`timescale 1ns/1ps
`default_nettype none
module vemc_host (
   input  wire logic       clk_sys,
   input  wire logic [7:0] reg_rdata_q,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // host clears pal when it sets secam; parity rides in caption msb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == 8'h61 && v[3]) v[1] = 1'b0;
      if (a == 8'h67) v[7] = ~^v[6:0];
      @(posedge clk_sys);
      #1 reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clk_sys);
      #1 reg_wr = 1'b0;
      reg_wdata = ~v;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys);
      #1 reg_rd = 1'b0;
      d = reg_rdata_q;
   endtask
   // recommended burst and a computed increment for one standard
   task automatic setup(input logic pal, input logic gs);
      real         r;
      logic [31:0] inc;
      r = pal ? 283.7516 / 1728.0 : 227.5 / 1716.0;
      inc = 32'(longint'(r * 4294967296.0));
      wr(8'h61, {3'b000, gs, 1'b0, 1'b1, pal, ~pal});
      wr(8'h62, pal ? (gs ? 8'h2d : 8'h2f) : (gs ? 8'h3f : 8'h43));
      wr(8'h63, inc[7:0]);
      wr(8'h64, inc[15:8]);
      wr(8'h65, inc[23:16]);
      wr(8'h66, inc[31:24]);
   endtask
endmodule
`default_nettype wire
